// ### common/asd_pkg.sv
// Shared map, codes and serial output mode decode for the ADC link
// Functional notes
// - Reset output code 0x30, 16-bit DDR bytewise, 4x.
// - 12-bit codes give 3x DDR, 6x SDR/one-lane.
// - 2x frame codes keep the 1x clock multiple.
// - 16-bit 1x modes give 4x or 8x clock.
// - Late output supply: soft reset, then digital reset.
// - Unstable clock at power-up: write 0x03 then 0x00.
// - Late external common-mode ref: digital reset afterwards.
// - Keep control port idle during critical conversions.
// - Power mode 11 resets datapath, never control port.
// - Writes apply at once; override waits for transfer.
package asd_pkg;
   localparam int ADDR_W = 13;
   localparam int HDR_BITS = 16;
   localparam int FRAME_BITS = 24;
   localparam int RW_BIT = 15;
   localparam logic [ADDR_W-1:0] ADR_CONFIG = 13'h000;
   localparam logic [ADDR_W-1:0] ADR_POWER = 13'h008;
   localparam logic [ADDR_W-1:0] ADR_SERCFG = 13'h021;
   localparam logic [ADDR_W-1:0] ADR_XFER = 13'h0FF;
   localparam logic [ADDR_W-1:0] ADR_OVERRIDE = 13'h100;
   localparam logic [7:0] SOFT_RESET_CODE = 8'h3C;
   localparam logic [7:0] SERCFG_RESET = 8'h30;
   localparam logic [7:0] OVERRIDE_RESET = 8'h00;
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_PWRDN = 2'h1;
   localparam logic [1:0] PM_STANDBY = 2'h2;
   localparam logic [1:0] PM_DIGRST = 2'h3;
   localparam logic [7:0] PM_ENTER_RESET = 8'h03;
   localparam logic [7:0] PM_LEAVE_RESET = 8'h00;
   localparam int XFER_BIT = 0;
   // Output config fields
   localparam int SER_BIT_12 = 1;
   localparam int SER_BIT_2X = 2;
   localparam int SER_BIT_BYTE = 4;
   localparam int SER_BIT_DDR = 5;
   localparam int SER_BIT_ONE = 6;
   localparam logic [4:0] WORD_BITS_16 = 5'h10;
   localparam logic [4:0] WORD_BITS_12 = 5'h0C;
   localparam logic [4:0] WORD_MSB = 5'h0F;
   localparam logic [1:0] SAMPLE_PAD = 2'h0;
   // Host register byte addresses on the bus
   localparam logic [3:0] HR_CMD = 4'h0;
   localparam logic [3:0] HR_STAT = 4'h4;
   localparam logic [3:0] HR_RXCFG = 4'h8;
   localparam logic [3:0] HR_RXDATA = 4'hC;
   localparam int CMD_RW_BIT = 24;
   localparam int CMD_ADR_LSB = 8;

   // Bit slots per lane in one word
   function automatic logic [4:0] asd_slots(input logic [7:0] c);
      logic [4:0] b;
      b = c[SER_BIT_12] ? WORD_BITS_12 : WORD_BITS_16;
      asd_slots = c[SER_BIT_ONE] ? b : (b >> 1);
   endfunction

   function automatic logic asd_ddr(input logic [7:0] c);
      asd_ddr = c[SER_BIT_ONE] | c[SER_BIT_DDR];
   endfunction

   // Data clock as a multiple of the sample rate
   function automatic logic [4:0] asd_dco_mult(input logic [7:0] c);
      asd_dco_mult = asd_ddr(c) ? (asd_slots(c) >> 1)
                                : asd_slots(c);
   endfunction

   // Word bit carried by a lane in a slot, MSB first
   function automatic logic [3:0] asd_lane_idx(input logic [7:0] c,
      input logic [4:0] s, input logic lane);
      logic [4:0] k;
      if (c[SER_BIT_ONE])
         k = s;
      else if (c[SER_BIT_BYTE])
         k = lane ? 5'(asd_slots(c) + s) : s;
      else
         k = 5'({s[3:0], lane});
      asd_lane_idx = 4'(WORD_MSB - k);
   endfunction
endpackage

// ### common/asd_link_if.sv
// Link between converter end and host end: control port and data lanes
`timescale 1ns/1ps
interface asd_link_if;
   logic sclk;
   logic csb_n;
   logic sdio_h_o;
   logic sdio_h_oe;
   logic sdio_d_o;
   logic sdio_d_oe;
   logic sdio;
   logic lane0;
   logic lane1;
   logic bclk;
   logic fclk;
   // Weak pull-down when nobody drives the data pin
   assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b0);
   modport dev (input sclk, csb_n, sdio,
      output sdio_d_o, sdio_d_oe, lane0, lane1, bclk, fclk);
   modport host (output sclk, csb_n, sdio_h_o, sdio_h_oe,
      input sdio, lane0, lane1, bclk, fclk);
endinterface

// ### logic/asd_device.sv
// Converter end: control port registers and serial output lanes
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module asd_device
   import asd_pkg::*;
   #(parameter int SLOT_DIV = 4)
   (
   input wire logic clk_sys,
   input wire logic reset,
   asd_link_if.dev link,
   input wire logic [13:0] sample_in,
   output logic sample_take,
   output logic [1:0] power_mode,
   output logic [7:0] override_active,
   output logic [4:0] dco_multiple
   );

   localparam logic [7:0] DIV_LAST = 8'(SLOT_DIV - 1);
   localparam logic [7:0] DIV_MID = 8'(SLOT_DIV / 2);

   logic [1:0] sclk_s;
   logic [1:0] csb_s;
   logic [1:0] sdio_s;
   logic sclk_d;
   logic [4:0] bit_cnt;
   logic [15:0] spi_sh;
   logic rw;
   logic [ADDR_W-1:0] addr;
   logic [7:0] out_sh;
   logic [7:0] ser_cfg;
   logic [7:0] ovr_shadow;
   logic [7:0] word_cfg;
   logic [15:0] word;
   logic [7:0] div_cnt;
   logic [4:0] slot_cnt;
   logic pair;

   // Control port edges, seen only after the second sync stage
   wire sclk_rise = sclk_s[1] & ~sclk_d;
   wire sclk_fall = ~sclk_s[1] & sclk_d;
   wire sel = ~csb_s[1];
   wire [15:0] next_sh = {spi_sh[14:0], sdio_s[1]};
   wire hdr_done = sel & sclk_rise & (bit_cnt == 5'(HDR_BITS - 1));
   wire frame_done = sel & sclk_rise & (bit_cnt == 5'(FRAME_BITS - 1));
   wire wr_fire = frame_done & ~rw;
   wire [7:0] wr_data = next_sh[7:0];
   wire [ADDR_W-1:0] hdr_addr = next_sh[ADDR_W-1:0];
   wire soft_rst = wr_fire & (addr == ADR_CONFIG)
      & (wr_data == SOFT_RESET_CODE);
   wire [7:0] rd_data =
      (hdr_addr == ADR_POWER) ? {6'h00, power_mode} :
      (hdr_addr == ADR_SERCFG) ? ser_cfg :
      (hdr_addr == ADR_OVERRIDE) ? ovr_shadow : 8'h00;
   wire drive_bit = sel & rw & (bit_cnt >= 5'(HDR_BITS));
   wire shift_out = sel & sclk_fall & (bit_cnt > 5'(HDR_BITS));

   // Control port: sync stages and serial shift
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         sclk_s <= 2'h0;
         csb_s <= 2'h3;
         sdio_s <= 2'h0;
         sclk_d <= 1'b0;
      end
      else
      begin
         sclk_s <= {sclk_s[0], link.sclk};
         csb_s <= {csb_s[0], link.csb_n};
         sdio_s <= {sdio_s[0], link.sdio};
         sclk_d <= sclk_s[1];
      end
   end

   // Only power-on reset clears this port; digital reset leaves it
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         bit_cnt <= 5'h00;
         spi_sh <= 16'h0000;
         rw <= 1'b0;
         addr <= ADR_CONFIG;
      end
      else if (!sel)
         bit_cnt <= 5'h00;
      else if (sclk_rise)
      begin
         spi_sh <= next_sh;
         bit_cnt <= bit_cnt + 5'h01;
         if (hdr_done)
         begin
            rw <= next_sh[RW_BIT];
            addr <= hdr_addr;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         out_sh <= 8'h00;
         link.sdio_d_o <= 1'b0;
         link.sdio_d_oe <= 1'b0;
      end
      else
      begin
         link.sdio_d_oe <= drive_bit;
         if (hdr_done)
         begin
            out_sh <= {rd_data[6:0], 1'b0};
            link.sdio_d_o <= rd_data[7];
         end
         else if (shift_out)
         begin
            out_sh <= {out_sh[6:0], 1'b0};
            link.sdio_d_o <= out_sh[7];
         end
      end
   end

   // Register file: every write lands at the last bit
   always_ff @(posedge clk_sys)
   begin
      if (reset || soft_rst)
      begin
         ser_cfg <= SERCFG_RESET;
         power_mode <= PM_NORMAL;
         ovr_shadow <= OVERRIDE_RESET;
         override_active <= OVERRIDE_RESET;
      end
      else if (wr_fire)
      begin
         if (addr == ADR_POWER)
            power_mode <= wr_data[1:0];
         if (addr == ADR_SERCFG)
            ser_cfg <= wr_data;
         if (addr == ADR_OVERRIDE)
            ovr_shadow <= wr_data;
         if (addr == ADR_XFER && wr_data[XFER_BIT])
            override_active <= ovr_shadow;
      end
   end

   // Serializer. Mode changes are taken at a word boundary so no
   // word is torn between two framings.
   wire dp_clear = (power_mode == PM_PWRDN) | (power_mode == PM_DIGRST);
   wire dp_run = power_mode == PM_NORMAL;
   wire slot_start = dp_run & (div_cnt == 8'h00);
   wire slot_mid = dp_run & (div_cnt == DIV_MID);
   wire word_start = slot_start & (slot_cnt == 5'h00);
   wire [7:0] cfg_now = word_start ? ser_cfg : word_cfg;
   wire [15:0] word_now = word_start ? {sample_in, SAMPLE_PAD} : word;
   wire [4:0] slots = asd_slots(cfg_now);
   wire slot_last = slot_cnt == (slots - 5'h01);
   wire ddr_now = asd_ddr(cfg_now);
   wire [3:0] idx0 = asd_lane_idx(cfg_now, slot_cnt, 1'b0);
   wire [3:0] idx1 = asd_lane_idx(cfg_now, slot_cnt, 1'b1);
   wire next_lane1 = ~cfg_now[SER_BIT_ONE] & word_now[idx1];
   wire next_fclk = cfg_now[SER_BIT_2X] ? ~pair
      : (slot_cnt < (slots >> 1));

   always_ff @(posedge clk_sys)
   begin
      if (reset || dp_clear)
      begin
         div_cnt <= 8'h00;
         slot_cnt <= 5'h00;
         pair <= 1'b0;
         word_cfg <= SERCFG_RESET;
         word <= 16'h0000;
      end
      else if (dp_run)
      begin
         div_cnt <= (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
         if (slot_start)
         begin
            word_cfg <= cfg_now;
            word <= word_now;
            slot_cnt <= slot_last ? 5'h00 : slot_cnt + 5'h01;
            if (slot_last)
               pair <= ~pair;
         end
      end
   end

   // Lanes change at slot start; SDR bit clock falls there, other bit clock edges sit mid-slot
   always_ff @(posedge clk_sys)
   begin
      if (reset || !dp_run)
      begin
         link.lane0 <= 1'b0;
         link.lane1 <= 1'b0;
         link.fclk <= 1'b0;
         link.bclk <= 1'b0;
         sample_take <= 1'b0;
      end
      else
      begin
         sample_take <= word_start;
         if (slot_start)
         begin
            link.lane0 <= word_now[idx0];
            link.lane1 <= next_lane1;
            link.fclk <= next_fclk;
            if (!ddr_now)
               link.bclk <= 1'b0;
         end
         else if (slot_mid)
            link.bclk <= ddr_now ? ~link.bclk : 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         dco_multiple <= asd_dco_mult(SERCFG_RESET);
      else
         dco_multiple <= asd_dco_mult(ser_cfg);
   end

endmodule // asd_device

// ### logic/asd_host.sv
// Host end: Wishbone-driven control port master and lane receiver
`timescale 1ns/1ps
module asd_host
   import asd_pkg::*;
   #(parameter int SPI_HALF = 4)
   (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [3:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   asd_link_if.host link,
   output logic [15:0] rx_word,
   output logic rx_valid
   );

   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP}
      asd_state_type;

   localparam logic [7:0] HALF_LAST = 8'(SPI_HALF - 1);

   asd_state_type state;
   logic [7:0] hcnt;
   logic [4:0] bitn;
   logic [23:0] tx_sh;
   logic rd_op;
   logic [7:0] rd_data;
   logic [7:0] rx_cfg;
   logic [1:0] l0_s;
   logic [1:0] l1_s;
   logic [1:0] bc_s;
   logic [1:0] fc_s;
   logic [1:0] sd_s;
   logic bc_d;
   logic fr_d;
   logic locked;
   logic [4:0] rx_cnt;
   logic [15:0] acc;
   logic [15:0] next_acc;

   wire req = wb_cyc & wb_stb & ~wb_ack;
   wire wr_req = req & wb_we & wb_sel[0];
   wire busy = state != ST_IDLE;
   wire cmd_go = wr_req & (wb_adr == HR_CMD) & ~busy;
   wire half_end = hcnt == HALF_LAST;
   wire last_bit = bitn == 5'(FRAME_BITS - 1);
   wire [4:0] next_bitn = bitn + 5'h01;
   wire rd_phase = rd_op & (next_bitn >= 5'(HDR_BITS));
   wire [31:0] rd_mux =
      (wb_adr == HR_STAT) ? {16'h0000, rd_data, 7'h00, busy} :
      (wb_adr == HR_RXCFG) ? {24'h000000, rx_cfg} :
      (wb_adr == HR_RXDATA) ? {16'h0000, rx_word} : 32'h00000000;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h00000000;
         rx_cfg <= SERCFG_RESET;
      end
      else
      begin
         wb_ack <= req;
         if (req)
            wb_dat_r <= rd_mux;
         if (wr_req && wb_adr == HR_RXCFG)
            rx_cfg <= wb_dat_w[7:0];
      end
   end

   // Control port master; sclk comes from this divider. Software
   // spaces its writes to keep the port quiet while sampling.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
         hcnt <= 8'h00;
         bitn <= 5'h00;
         tx_sh <= 24'h000000;
         rd_op <= 1'b0;
         rd_data <= 8'h00;
         link.sclk <= 1'b0;
         link.csb_n <= 1'b1;
         link.sdio_h_o <= 1'b0;
         link.sdio_h_oe <= 1'b0;
      end
      else
      begin
         hcnt <= (state == ST_IDLE || half_end) ? 8'h00 : hcnt + 8'h01;
         case (state)
            ST_IDLE:
               if (cmd_go)
               begin
                  rd_op <= wb_dat_w[CMD_RW_BIT];
                  tx_sh <= {wb_dat_w[CMD_RW_BIT], 2'h0,
                     wb_dat_w[CMD_ADR_LSB +: ADDR_W], wb_dat_w[7:0]};
                  bitn <= 5'h00;
                  link.csb_n <= 1'b0;
                  link.sdio_h_o <= wb_dat_w[CMD_RW_BIT];
                  link.sdio_h_oe <= 1'b1;
                  state <= ST_LOW;
               end
            ST_LOW:
               if (half_end)
               begin
                  link.sclk <= 1'b1;
                  state <= ST_HIGH;
               end
            ST_HIGH:
               if (half_end)
               begin
                  link.sclk <= 1'b0;
                  if (rd_op && bitn >= 5'(HDR_BITS))
                     rd_data <= {rd_data[6:0], sd_s[1]};
                  if (last_bit)
                  begin
                     link.csb_n <= 1'b1;
                     link.sdio_h_oe <= 1'b0;
                     state <= ST_GAP;
                  end
                  else
                  begin
                     bitn <= next_bitn;
                     tx_sh <= {tx_sh[22:0], 1'b0};
                     link.sdio_h_o <= tx_sh[22];
                     link.sdio_h_oe <= ~rd_phase;
                     state <= ST_LOW;
                  end
               end
            ST_GAP:
               if (half_end)
                  state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Lane receiver: captures on bit clock edges, aligns on frame rise
   wire bc_edge = bc_s[1] ^ bc_d;
   wire cap = asd_ddr(rx_cfg) ? bc_edge : (bc_s[1] & ~bc_d);
   wire fr_start = fc_s[1] & ~fr_d;
   wire [4:0] slot = fr_start ? 5'h00 : rx_cnt;
   wire [4:0] slots = asd_slots(rx_cfg);
   wire slot_last = slot == (slots - 5'h01);
   wire [3:0] idx0 = asd_lane_idx(rx_cfg, slot, 1'b0);
   wire [3:0] idx1 = asd_lane_idx(rx_cfg, slot, 1'b1);

   always_comb
   begin
      next_acc = acc;
      next_acc[idx0] = l0_s[1];
      if (!rx_cfg[SER_BIT_ONE])
         next_acc[idx1] = l1_s[1];
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         l0_s <= 2'h0;
         l1_s <= 2'h0;
         bc_s <= 2'h0;
         fc_s <= 2'h0;
         sd_s <= 2'h0;
         bc_d <= 1'b0;
      end
      else
      begin
         l0_s <= {l0_s[0], link.lane0};
         l1_s <= {l1_s[0], link.lane1};
         bc_s <= {bc_s[0], link.bclk};
         fc_s <= {fc_s[0], link.fclk};
         sd_s <= {sd_s[0], link.sdio};
         bc_d <= bc_s[1];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         fr_d <= 1'b0;
         locked <= 1'b0;
         rx_cnt <= 5'h00;
         acc <= 16'h0000;
         rx_word <= 16'h0000;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (cap)
         begin
            fr_d <= fc_s[1];
            if (fr_start)
               locked <= 1'b1;
            rx_cnt <= slot_last ? 5'h00 : slot + 5'h01;
            acc <= slot_last ? 16'h0000 : next_acc;
            if (slot_last && (locked || fr_start))
            begin
               rx_word <= next_acc;
               rx_valid <= 1'b1;
            end
         end
      end
   end

endmodule // asd_host

// ### sim/asd_link_assertions.sv
// Checker for the converter link, power state and host bus handshake
`timescale 1ns/1ps
module asd_link_assertions
   import asd_pkg::*;
   (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdio_h_oe,
   input wire logic sdio_d_oe,
   input wire logic lane0,
   input wire logic lane1,
   input wire logic bclk,
   input wire logic fclk,
   input wire logic [1:0] power_mode,
   input wire logic [4:0] dco_multiple,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_ack
   );
   logic [5:0] rises;

   // Serial clock rises seen in the current frame
   always_ff @(posedge clk_sys)
   begin
      if (reset || csb_n)
         rises <= 6'h00;
      else if ($rose(sclk))
         rises <= rises + 6'h01;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   host_in_frame_a: assert property (sdio_h_oe |-> !csb_n)
      else $error("host drives data pin outside a frame");
   no_contend_a: assert property (!(sdio_h_oe && sdio_d_oe))
      else $error("both ends drive the data pin");
   dev_quiet_a: assert property (csb_n [*6] |-> !sdio_d_oe)
      else $error("device drives data pin while deselected");
   sclk_shape_a: assert property ($rose(sclk) |->
      sclk [*4] ##1 (!sclk) [*4])
      else $error("serial clock phase length wrong");
   frame_bits_a: assert property ($rose(csb_n) |-> rises == 6'h18)
      else $error("frame is not 24 bits");
   dco_reset_a: assert property ($fell(reset) |-> dco_multiple == 5'h04)
      else $error("data clock multiple not 4 after reset");
   lanes_off_a: assert property ((power_mode == PM_DIGRST) [*3] |->
      !lane0 && !lane1 && !bclk && !fclk)
      else $error("lanes active in digital reset");
   // Lanes must sit still just after the bit clock rise
   lane_hold_a: assert property ($rose(bclk) ##1
      power_mode == PM_NORMAL |-> $stable(lane0) && $stable(lane1))
      else $error("lane changed just after capture edge");
   bclk_rate_a: assert property ($changed(bclk) ##1
      power_mode == PM_NORMAL |-> $stable(bclk))
      else $error("data clock toggled on two cycles in a row");
   ack_time_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("bus ack late");
   ack_once_a: assert property (wb_ack |=> !wb_ack)
      else $error("bus ack longer than one cycle");

   cover property ($rose(csb_n));
   cover property ((power_mode == PM_DIGRST) [*3]);
   cover property ($rose(fclk));
endmodule // asd_link_assertions

// ### sim/testbench.sv
// Bench joining converter end and host end over the link
`timescale 1ns/1ps
module testbench;
   import asd_pkg::*;
   localparam int SLOT = 4;
   logic clk_sys, reset, wb_cyc, wb_stb, wb_we, wb_ack, rx_valid;
   logic sample_take;
   logic [3:0] wb_adr;
   logic [3:0] wb_sel = 4'hF;
   logic [31:0] wb_dat_w, wb_dat_r;
   logic [13:0] sample_in;
   logic [15:0] rx_word;
   logic [1:0] power_mode;
   logic [7:0] override_active;
   logic [4:0] dco_multiple;
   int num_errors = 0;
   int checked = 0;
   logic [7:0] codes [18] = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h34, 8'h24,
      8'h14, 8'h04, 8'h40, 8'h32, 8'h22, 8'h12, 8'h02, 8'h36, 8'h26,
      8'h16, 8'h06, 8'h42};
   int mults [18] = '{4, 4, 8, 8, 4, 4, 8, 8, 8, 3, 3, 6, 6, 3, 3, 6, 6, 6};

   asd_link_if link ();
   asd_device #(.SLOT_DIV(SLOT)) i_asd_device (.clk_sys(clk_sys),
      .reset(reset), .link(link), .sample_in(sample_in),
      .sample_take(sample_take), .power_mode(power_mode),
      .override_active(override_active), .dco_multiple(dco_multiple));
   asd_host #(.SPI_HALF(4)) i_asd_host (.clk_sys(clk_sys),
      .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
      .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .link(link),
      .rx_word(rx_word), .rx_valid(rx_valid));
   asd_link_assertions i_asd_link_assertions (.clk_sys(clk_sys),
      .reset(reset), .sclk(link.sclk), .csb_n(link.csb_n),
      .sdio_h_oe(link.sdio_h_oe), .sdio_d_oe(link.sdio_d_oe),
      .lane0(link.lane0), .lane1(link.lane1), .bclk(link.bclk),
      .fclk(link.fclk), .power_mode(power_mode),
      .dco_multiple(dco_multiple), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_ack(wb_ack));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic hang(input string what);
      num_errors++;
      $display("Error %0t: timeout on %s", $time, what);
      tally_and_finish();
   endtask

   task automatic chk_val(input string what, input logic [31:0] got,
      input logic [31:0] exp);
      checked++;
      if (got !== exp)
         $display("Error %0t: %s got %h want %h", $time, what, got, exp);
      if (got !== exp)
         num_errors++;
   endtask

   task automatic chk_cnt(input string what, input int got, input int exp);
      checked++;
      if (got != exp)
         $display("Error %0t: %s got %0d want %0d", $time, what, got, exp);
      if (got != exp)
         num_errors++;
   endtask

   // One classic cycle; the request holds until ack is sampled
   task automatic wb_cycle(input logic we, input logic [3:0] adr,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_w <= d;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 50);
      if (wb_ack !== 1'b1)
         hang("bus ack");
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   // Control port access, then poll until the frame is gone
   task automatic ctl(input logic rd, input logic [12:0] a,
      input logic [7:0] d, output logic [7:0] q);
      logic [31:0] r;
      int n;
      wb_cycle(1'b1, HR_CMD, {7'h00, rd, 3'h0, a, d}, r);
      n = 0;
      do
      begin
         wb_cycle(1'b0, HR_STAT, 32'h0, r);
         n++;
      end
      while (r[0] !== 1'b0 && n < 500);
      if (r[0] !== 1'b0)
         hang("control port");
      q = r[15:8];
   endtask

   task automatic wait_pm(input logic [1:0] m);
      int n;
      n = 0;
      while (power_mode !== m && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk_val("power mode", power_mode, m);
   endtask

   task automatic rx_check(input int bits);
      int n, k;
      logic idle;
      logic [15:0] e;
      logic [31:0] r;
      n = 0;
      k = 0;
      idle = 1'b1;
      while (k < 3 && n < 3000)
      begin
         @(posedge clk_sys);
         n++;
         if (rx_valid === 1'b1)
            k++;
         if (link.csb_n !== 1'b1)
            idle = 1'b0;
      end
      if (k < 3)
         hang("received word");
      e = bits == 16 ? {sample_in, 2'b00} : {sample_in[13:2], 4'h0};
      chk_val("word", rx_word, e);
      chk_val("port idle", idle, 1'b1);
      wb_cycle(1'b0, HR_RXDATA, 32'h0, r);
      chk_val("data register", r, {16'h0000, e});
   endtask

   task automatic test_reset;
      logic [31:0] r;
      logic [7:0] q;
      chk_val("reset multiple", dco_multiple, 5'h04);
      chk_val("reset override", override_active, 8'h00);
      wb_cycle(1'b0, 4'h2, 32'h0, r);
      chk_val("unmapped", r, 32'h0);
      // A command while the port is busy must be dropped
      wb_cycle(1'b1, HR_CMD, {8'h01, 3'h0, ADR_SERCFG, 8'h00}, r);
      ctl(1'b0, ADR_POWER, PM_ENTER_RESET, q);
      chk_val("reset code", q, 8'h30);
      chk_val("busy command dropped", power_mode, PM_NORMAL);
      $display("reset test done");
   endtask

   task automatic test_mode(input int i);
      int bits, slots, hi, br, n, st, tk;
      logic pf, pb, twox;
      logic [7:0] q;
      logic [31:0] r;
      bits = i < 9 ? 16 : 12;
      slots = (i == 8 || i == 17) ? bits : bits / 2;
      twox = i inside {[4:7], [13:16]};
      sample_in <= 14'h1A5 + 14'(i) * 14'h0B3;
      ctl(1'b0, ADR_SERCFG, codes[i], q);
      wb_cycle(1'b1, HR_RXCFG, {24'h0, codes[i]}, r);
      ctl(1'b1, ADR_SERCFG, 8'h00, q);
      chk_val("code readback", q, codes[i]);
      hi = 0;
      br = 0;
      n = 0;
      st = 0;
      tk = 0;
      pf = link.fclk;
      pb = link.bclk;
      // Count over one frame clock period, rise to rise
      while (st < 2 && n < 3000)
      begin
         @(posedge clk_sys);
         n++;
         if (st == 1 && link.fclk === 1'b1)
            hi++;
         if (st == 1 && link.bclk === 1'b1 && pb === 1'b0)
            br++;
         if (st == 1 && sample_take === 1'b1)
            tk++;
         if (link.fclk === 1'b1 && pf === 1'b0)
            st++;
         pf = link.fclk;
         pb = link.bclk;
      end
      if (st < 2)
         hang("frame clock");
      chk_val("multiple", dco_multiple, mults[i]);
      chk_cnt("clock rises", br, twox ? 2 * mults[i] : mults[i]);
      chk_cnt("frame high", hi, twox ? slots * SLOT : slots * SLOT / 2);
      chk_cnt("samples taken", tk, twox ? 2 : 1);
      rx_check(bits);
      $display("mode %h done", codes[i]);
   endtask

   task automatic test_recover;
      logic [7:0] q;
      logic [31:0] r;
      ctl(1'b0, ADR_OVERRIDE, 8'h05, q);
      chk_val("override early", override_active, 8'h00);
      ctl(1'b0, ADR_XFER, 8'h01, q);
      chk_val("override live", override_active, 8'h05);
      ctl(1'b0, ADR_CONFIG, 8'h3C, q);
      ctl(1'b1, ADR_SERCFG, 8'h00, q);
      chk_val("code after soft reset", q, 8'h30);
      wb_cycle(1'b1, HR_RXCFG, 32'h30, r);
      for (int m = 3; m > 0; m--)
      begin
         ctl(1'b0, ADR_POWER, 8'(m), q);
         wait_pm(2'(m));
         ctl(1'b1, ADR_POWER, 8'h00, q);
         chk_val("power readback", q, 8'(m));
         chk_val("lanes", {link.lane0, link.lane1, link.bclk, link.fclk},
            4'h0);
         ctl(1'b0, ADR_POWER, 8'h00, q);
         wait_pm(2'h0);
         rx_check(16);
      end
      $display("recovery test done");
   endtask

   initial
   begin
      reset = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_dat_w = 32'h0;
      sample_in = 14'h0000;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      test_reset();
      for (int i = 0; i < 18; i++)
         test_mode(i);
      test_recover();
      tally_and_finish();
   end
endmodule // testbench
